// File: hrpc_pkg.sv
package hrpc_pkg;
	localparam int unsigned MCLK_HZ = 25000000;
	localparam int unsigned RST_MIN_CYC = 20;
	localparam logic [4:0] RST_MIN_CNT = 5'd20;
	localparam logic [19:0] RESET_VECTOR_ADDR = 20'hFFFFC;
	localparam int unsigned FLAG_RSVD_BIT = 15;
	localparam int unsigned P4_CS0_BIT = 4;
	localparam int unsigned P5_WR_BIT = 0;
	localparam int unsigned P5_UBE_BIT = 1;
	localparam int unsigned P5_RD_BIT = 2;
	localparam int unsigned P5_BCLK_BIT = 3;
	localparam int unsigned P5_HOLD_ACKNOWLEDGE_BIT = 4;
	localparam int unsigned P5_HOLD_BIT = 5;
	localparam int unsigned P5_ALE_BIT = 6;
	localparam logic [7:0] P4_ADDR_MASK = 8'h0F;
	localparam logic [7:0] P4_PULLUP_MASK = 8'hE0;
	localparam logic [7:0] P5_OUT_MASK = 8'h5F;
	localparam logic [7:0] P5_RESET_LEVEL = 8'h05;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	typedef enum logic [1:0] {
		HRPC_IN_RESET = 2'b00,
		HRPC_FETCH = 2'b01,
		HRPC_RUN = 2'b11
	} hrpc_state_e;
endpackage

// File: hrpc_sync_if.sv
`timescale 1ns/1ns
interface hrpc_sync_if;
	logic [2:0] raw;
	logic [2:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface

// File: hrpc_sync.sv
`timescale 1ns/1ns
module hrpc_sync (
	input wire logic mclk_in,
	input wire logic srst_in,
	hrpc_sync_if.snk sif
);
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	// pin levels come from outside the clock domain
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
		end
		else
		begin
			meta_r <= sif.raw;
			sync_r <= meta_r;
		end
	end
	assign sif.synced = sync_r;
endmodule // hrpc_sync

// File: hrpc_ctrl.sv
`timescale 1ns/1ns
// Operation
// - on release with stable clock, fetch first instruction from reset vector
// - software reset reaches exactly the same state as pin reset; here reset_fault_out is kept, while a valid pin reset clears it
// - single-chip mode in reset: all port pins are floating inputs
// - mode high: port 0 data input; port 1 depends on bus-width pin
// - mode high: ports 2, 3 and port 4 bits 0-3 drive undefined address
// - mode high: port 4 bit 4 first chip select driven high
// - mode high: port 4 bits 5-7 floating inputs with pull-ups on
// - mode high: port 5 bit 0 write and bit 2 read strobe high
// - mode high: port 5 bit 1 upper byte enable, undefined level
// - mode high: port 5 bit 3 outputs the bus clock
// - mode high: hold acknowledge on port 5 bit 4 is the inverse of the hold request input
// - mode high: port 5 bit 6 address latch strobe driven low
// - mode high: port 5 bit 7 stays a floating input
// - flag register bit 15 is reserved with no function
module hrpc_ctrl (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic reset_pin_n_in,
	input wire logic processor_mode_pin_in,
	input wire logic bus_width_pin_in,
	input wire logic hold_request_in,
	input wire logic soft_reset_in,
	input wire logic [15:0] flag_wdata_in,
	input wire logic flag_we_in,
	output logic cpu_reset_out,
	output logic fetch_req_out,
	output logic [19:0] fetch_addr_out,
	output logic [15:0] flag_register_out,
	output logic reset_fault_out,
	output logic [7:0] p0_oe_out,
	output logic [7:0] p1_oe_out,
	output logic [7:0] p2_oe_out,
	output logic [7:0] p3_oe_out,
	output logic [7:0] p4_oe_out,
	output logic [7:0] p4_out,
	output logic [7:0] p4_pullup_out,
	output logic [7:0] p5_oe_out,
	output logic [7:0] p5_out,
	output logic p1_data_bus_out
);
	import hrpc_pkg::*;
	hrpc_sync_if sif ();
	hrpc_state_e state_r;
	hrpc_state_e state_nxt;
	logic [4:0] low_cnt_r;
	logic valid_r;
	logic prev_low_r;
	logic bclk_r;
	logic rst_low;
	logic mode_s;
	logic bw_s;
	logic hold_s;
	logic in_reset;
	assign sif.raw = {hold_request_in, bus_width_pin_in, processor_mode_pin_in};
	hrpc_sync u_sync (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.sif(sif.snk)
	);
	logic [1:0] rpin_r;
	// reset pin takes two flops before the counter looks at it
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			rpin_r <= 2'h0;
		else
			rpin_r <= {rpin_r[0], reset_pin_n_in};
	end
	assign rst_low = ~rpin_r[1];
	assign mode_s = sif.synced[0];
	assign bw_s = sif.synced[1];
	assign hold_s = sif.synced[2];
	// a short glitch below the minimum is ignored rather than half-resetting the core
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			low_cnt_r <= 5'h00;
			valid_r <= 1'b1;
			prev_low_r <= 1'b1;
			reset_fault_out <= 1'b0;
		end
		else
		begin
			prev_low_r <= rst_low;
			if (rst_low)
			begin
				if (low_cnt_r != RST_MIN_CNT)
					low_cnt_r <= low_cnt_r + 5'h01;
				if (low_cnt_r == RST_MIN_CNT - 5'h01)
					valid_r <= 1'b1;
			end
			else
			begin
				low_cnt_r <= 5'h00;
				if (prev_low_r && !valid_r)
					reset_fault_out <= 1'b1;
				if (prev_low_r && valid_r)
					reset_fault_out <= 1'b0;
				if (prev_low_r)
					valid_r <= 1'b0;
			end
		end
	end
	// software reset forces reset directly, without the held pin's minimum-length check
	assign in_reset = srst_in | soft_reset_in | (rst_low & (valid_r | state_r == HRPC_IN_RESET));
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			HRPC_IN_RESET:
				if (!rst_low)
					state_nxt = HRPC_FETCH;
			HRPC_FETCH:
				state_nxt = HRPC_RUN;
			HRPC_RUN:
				state_nxt = HRPC_RUN;
			default:
				state_nxt = HRPC_IN_RESET;
		endcase
	end
	always_ff @(posedge mclk_in)
	begin
		if (in_reset && (srst_in || soft_reset_in || valid_r || state_r == HRPC_IN_RESET))
			state_r <= HRPC_IN_RESET;
		else
			state_r <= state_nxt;
	end
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || soft_reset_in)
		begin
			cpu_reset_out <= 1'b1;
			fetch_req_out <= 1'b0;
			fetch_addr_out <= RESET_VECTOR_ADDR;
		end
		else
		begin
			cpu_reset_out <= (state_r == HRPC_IN_RESET);
			fetch_req_out <= (state_r == HRPC_FETCH);
			fetch_addr_out <= RESET_VECTOR_ADDR;
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || soft_reset_in || state_r == HRPC_IN_RESET)
			flag_register_out <= FLAG_RESET;
		else if (flag_we_in)
		begin
			flag_register_out <= flag_wdata_in;
			flag_register_out[FLAG_RSVD_BIT] <= 1'b0;
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			bclk_r <= 1'b0;
		else
			bclk_r <= ~bclk_r;
	end
	// pin states only while held in reset, except p1_data_bus_out which follows mode and width pins every cycle; after release the port blocks own the rest
	always_ff @(posedge mclk_in)
	begin
		p0_oe_out <= 8'h00;
		p1_oe_out <= 8'h00;
		p1_data_bus_out <= mode_s & ~bw_s;
		p2_oe_out <= 8'h00;
		p3_oe_out <= 8'h00;
		p4_oe_out <= 8'h00;
		p4_out <= 8'h00;
		p4_pullup_out <= 8'h00;
		p5_oe_out <= 8'h00;
		p5_out <= 8'h00;
		if (srst_in || state_r == HRPC_IN_RESET)
		begin
			if (mode_s)
			begin
				p2_oe_out <= 8'hFF;
				p3_oe_out <= 8'hFF;
				p4_oe_out <= P4_ADDR_MASK | (8'h01 << P4_CS0_BIT);
				p4_out[P4_CS0_BIT] <= 1'b1;
				p4_pullup_out <= P4_PULLUP_MASK;
				p5_oe_out <= P5_OUT_MASK;
				p5_out <= P5_RESET_LEVEL;
				p5_out[P5_BCLK_BIT] <= bclk_r;
				p5_out[P5_HOLD_ACKNOWLEDGE_BIT] <= ~hold_s;
			end
		end
	end
endmodule // hrpc_ctrl

// File: hrpc_ctrl_properties.sv
`timescale 1ns/1ns
module hrpc_ctrl_properties
	import hrpc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic processor_mode_pin_in,
	input wire logic cpu_reset_out,
	input wire logic fetch_req_out,
	input wire logic [19:0] fetch_addr_out,
	input wire logic [15:0] flag_register_out,
	input wire logic [7:0] p4_oe_out,
	input wire logic [7:0] p4_out,
	input wire logic [7:0] p5_oe_out,
	input wire logic [7:0] p5_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	// mode pin passes two sync flops and a port register, so five cycles settle it
	sequence ext_s; (processor_mode_pin_in && cpu_reset_out) [*5]; endsequence
	sequence sc_s; (!processor_mode_pin_in && cpu_reset_out) [*5]; endsequence
	a_vector_addr: assert property (fetch_req_out |-> fetch_addr_out == RESET_VECTOR_ADDR)
		else $error("fetch address");
	a_fetch_pulse: assert property (fetch_req_out |=> !fetch_req_out)
		else $error("fetch width");
	a_exit_fetch: assert property ($fell(cpu_reset_out) |-> fetch_req_out)
		else $error("exit without fetch");
	a_single_float: assert property (sc_s |-> (p4_oe_out | p5_oe_out) == 8'h00)
		else $error("pin driven");
	a_cs_drive: assert property (ext_s |-> p4_oe_out == 8'h1F && p4_out[P4_CS0_BIT])
		else $error("select or address");
	a_strobe_lvl: assert property (ext_s |-> p5_oe_out == P5_OUT_MASK && p5_out[0] && p5_out[2]
		&& !p5_out[P5_ALE_BIT])
		else $error("strobes");
	a_bclk_toggle: assert property (ext_s |-> p5_out[3] != $past(p5_out[3]))
		else $error("bus clock");
	a_flag_rsvd: assert property (!flag_register_out[FLAG_RSVD_BIT])
		else $error("flag bit");
	c_fetch: cover property (fetch_req_out);
	c_ext: cover property (ext_s);
	c_single: cover property (sc_s);
endmodule // hrpc_ctrl_properties
bind hrpc_ctrl hrpc_ctrl_properties u_props (.*);

// File: hrpc_rst_src.sv
`timescale 1ns/1ns
module hrpc_rst_src (
	input wire logic mclk_in,
	input wire logic start_in,
	input wire logic [5:0] len_in,
	output logic reset_pin_n_out
);
	logic [5:0] cnt_r = 6'h00;
	always @(posedge mclk_in)
		if (start_in)
			cnt_r <= len_in;
		else if (cnt_r != 6'h00)
			cnt_r <= cnt_r - 6'h01;
	// pin has a pull-up, so it reads high once released
	assign reset_pin_n_out = (cnt_r == 6'h00);
endmodule // hrpc_rst_src

// File: tb.sv
`timescale 1ns/1ns
module tb;
	import hrpc_pkg::*;
	logic mclk_in = 0, srst_in = 1, processor_mode_pin_in = 0, bus_width_pin_in = 0, go = 0;
	logic hold_request_in = 1, soft_reset_in = 0, flag_we_in = 0, reset_pin_n_in;
	logic cpu_reset_out, fetch_req_out, reset_fault_out, p1_data_bus_out;
	logic [5:0] len = 6'h00;
	logic [15:0] flag_wdata_in = 16'h0000, flag_register_out;
	logic [19:0] fetch_addr_out;
	logic [7:0] p0_oe_out, p1_oe_out, p2_oe_out, p3_oe_out, p4_oe_out, p4_out, p4_pullup_out;
	logic [7:0] p5_oe_out, p5_out;
	int n_fail = 0, total_checks = 0, cyc = 0;
	hrpc_ctrl dut (.*);
	hrpc_rst_src ext (.mclk_in, .start_in(go), .len_in(len), .reset_pin_n_out(reset_pin_n_in));
	initial forever #20 mclk_in = ~mclk_in;
	task automatic chk(string s, logic [19:0] e, logic [19:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failed %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic pulse(int n);
		@(negedge mclk_in);
		go = 1;
		len = 6'(n);
		@(negedge mclk_in);
		go = 0;
		repeat (n + 1) @(negedge mclk_in);
	endtask
	task automatic fetch();
		for (int i = 0; i < 10 && fetch_req_out !== 1'b1; i++)
			@(negedge mclk_in);
		chk("fetch", RESET_VECTOR_ADDR, fetch_req_out ? fetch_addr_out : 20'h0);
		chk("run", 20'h0, 20'(cpu_reset_out));
	endtask
	task automatic t_pin(logic m, logic bw);
		processor_mode_pin_in = m;
		bus_width_pin_in = bw;
		pulse(25);
		chk("held", 20'h1, 20'(cpu_reset_out));
		chk("inputs", 20'h0, 20'(p0_oe_out | p1_oe_out | (m ? 8'h00 : p2_oe_out | p5_oe_out)));
		if (m)
		begin
			chk("addr", 20'h1F, 20'(p2_oe_out & p3_oe_out & p4_oe_out));
			chk("ctrl", 20'hF0005, {p4_out[4], p4_pullup_out[7:5], 8'h00, p5_out & 8'h55});
			chk("bus", 20'(!bw), 20'(p1_data_bus_out));
		end
		fetch();
		$display("pin reset done mode %0d width %0d", m, bw);
	endtask
	task automatic t_short();
		pulse(19);
		repeat (3) @(negedge mclk_in);
		chk("fault", 20'h2, 20'({reset_fault_out, cpu_reset_out}));
		$display("short pulse done");
	endtask
	task automatic t_soft();
		soft_reset_in = 1;
		repeat (3) @(negedge mclk_in);
		chk("soft", 20'h1, 20'(cpu_reset_out));
		soft_reset_in = 0;
		fetch();
		chk("flags", 20'(FLAG_RESET), 20'(flag_register_out));
		$display("soft reset done");
	endtask
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			conclude();
		end
	end
	initial
	begin
		repeat (6) @(negedge mclk_in);
		srst_in = 0;
		repeat (8) @(negedge mclk_in);
		t_pin(1'b0, 1'b0);
		t_pin(1'b1, 1'b0);
		t_pin(1'b1, 1'b1);
		t_short();
		t_soft();
		conclude();
	end
endmodule // tb
